// File: hw/rpa_pkg.sv
package rpa_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int STRB_W = 4;
  localparam int LINE_W = 12;
  localparam int TILE_W = 9;
  localparam int NPLANE = 3;
  localparam int PROD_W = DATA_W + LINE_W;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_LB_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LB_TILE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LB_STRIDE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CT_BASE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CT_TILE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CT_STRIDE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CB_BASE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CB_TILE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CB_STRIDE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_LAST_ADDR = 8'h2C;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_BASE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_STRIDE = 32'h0000_0000;
  localparam logic [TILE_W-1:0] RST_TILE = 9'h010;
  localparam logic RST_RASTER = 1'b1;
  localparam int CTRL_RASTER_BIT = 0;
  localparam int STAT_REFUSED_LSB = 0;

  localparam logic [TILE_W-1:0] TILE_16 = 9'h010;
  localparam logic [TILE_W-1:0] TILE_32 = 9'h020;
  localparam logic [TILE_W-1:0] TILE_64 = 9'h040;
  localparam logic [TILE_W-1:0] TILE_128 = 9'h080;
  localparam logic [TILE_W-1:0] TILE_256 = 9'h100;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PLANE_LUMA_BTM = 2'b00,
    PLANE_CHROMA_TOP = 2'b01,
    PLANE_CHROMA_BTM = 2'b10,
    PLANE_NONE = 2'b11
  } rpa_plane_t;

  typedef enum logic [2:0] {
    KIND_NONE = 3'b000,
    KIND_BASE = 3'b001,
    KIND_TILE = 3'b010,
    KIND_STRIDE = 3'b011,
    KIND_CTRL = 3'b100,
    KIND_STATUS = 3'b101,
    KIND_LAST = 3'b110
  } rpa_kind_t;

  typedef struct packed {
    rpa_kind_t kind;
    rpa_plane_t plane;
  } rpa_slot_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic tile_code_ok(input logic [TILE_W-1:0] code);
    return (code == TILE_16) || (code == TILE_32) || (code == TILE_64) ||
      (code == TILE_128) || (code == TILE_256);
  endfunction

  // Low two address bits are ignored: every register is one word
  function automatic rpa_slot_t slot_decode(input logic [ADDR_W-1:0] addr);
    rpa_slot_t s;
    logic [ADDR_W-1:0] a;
    a = {addr[ADDR_W-1:2], 2'b00};
    s.kind = KIND_NONE;
    s.plane = PLANE_NONE;
    if (a == OFS_LB_BASE) begin
      s = '{KIND_BASE, PLANE_LUMA_BTM};
    end else if (a == OFS_LB_TILE) begin
      s = '{KIND_TILE, PLANE_LUMA_BTM};
    end else if (a == OFS_LB_STRIDE) begin
      s = '{KIND_STRIDE, PLANE_LUMA_BTM};
    end else if (a == OFS_CT_BASE) begin
      s = '{KIND_BASE, PLANE_CHROMA_TOP};
    end else if (a == OFS_CT_TILE) begin
      s = '{KIND_TILE, PLANE_CHROMA_TOP};
    end else if (a == OFS_CT_STRIDE) begin
      s = '{KIND_STRIDE, PLANE_CHROMA_TOP};
    end else if (a == OFS_CB_BASE) begin
      s = '{KIND_BASE, PLANE_CHROMA_BTM};
    end else if (a == OFS_CB_TILE) begin
      s = '{KIND_TILE, PLANE_CHROMA_BTM};
    end else if (a == OFS_CB_STRIDE) begin
      s = '{KIND_STRIDE, PLANE_CHROMA_BTM};
    end else if (a == OFS_CTRL) begin
      s.kind = KIND_CTRL;
    end else if (a == OFS_STATUS) begin
      s.kind = KIND_STATUS;
    end else if (a == OFS_LAST_ADDR) begin
      s.kind = KIND_LAST;
    end
    return s;
  endfunction

endpackage

// File: hw/rpa_plane_if.sv
`timescale 1ns/1ps
interface rpa_plane_if;
  logic wr_base;
  logic wr_stride;
  logic wr_tile;
  logic [rpa_pkg::DATA_W-1:0] wdata;
  logic [rpa_pkg::STRB_W-1:0] wstrb;
  logic [rpa_pkg::DATA_W-1:0] base;
  logic [rpa_pkg::DATA_W-1:0] stride;
  logic [rpa_pkg::TILE_W-1:0] tile;
  logic tile_refused;

  modport regs (
    input wr_base, wr_stride, wr_tile, wdata, wstrb,
    output base, stride, tile, tile_refused
  );
  modport ctl (
    output wr_base, wr_stride, wr_tile, wdata, wstrb,
    input base, stride, tile, tile_refused
  );
endinterface

// File: hw/rpa_plane_regs.sv
`timescale 1ns/1ps
module rpa_plane_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  rpa_plane_if.regs pif
);
  logic [rpa_pkg::DATA_W-1:0] base_ff, nxt_base;
  logic [rpa_pkg::DATA_W-1:0] stride_ff, nxt_stride;
  logic [rpa_pkg::TILE_W-1:0] tile_ff, nxt_tile;
  logic [rpa_pkg::DATA_W-1:0] tile_cand;
  logic refused;

  always_comb begin
    nxt_base = base_ff;
    nxt_stride = stride_ff;
    nxt_tile = tile_ff;
    refused = 1'b0;
    tile_cand = rpa_pkg::merge_bytes({{(rpa_pkg::DATA_W-rpa_pkg::TILE_W){1'b0}}, tile_ff},
      pif.wdata, pif.wstrb);
    if (pif.wr_base) begin
      nxt_base = rpa_pkg::merge_bytes(base_ff, pif.wdata, pif.wstrb); // RULE8
    end
    if (pif.wr_stride) begin
      nxt_stride = rpa_pkg::merge_bytes(stride_ff, pif.wdata, pif.wstrb); // RULE8
    end
    if (pif.wr_tile) begin
      // Reserved codes never reach the engine; the old width stays
      if (rpa_pkg::tile_code_ok(tile_cand[rpa_pkg::TILE_W-1:0])) begin
        nxt_tile = tile_cand[rpa_pkg::TILE_W-1:0]; // RULE4 RULE9
      end else begin
        refused = 1'b1; // RULE4
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      base_ff <= rpa_pkg::RST_BASE; // RULE8
      stride_ff <= rpa_pkg::RST_STRIDE; // RULE8
      tile_ff <= rpa_pkg::RST_TILE;
    end else begin
      base_ff <= nxt_base;
      stride_ff <= nxt_stride;
      tile_ff <= nxt_tile;
    end
  end

  assign pif.base = base_ff;
  assign pif.stride = stride_ff;
  assign pif.tile = tile_ff;
  assign pif.tile_refused = refused;
endmodule

// File: hw/rpa_line_addr.sv
`timescale 1ns/1ps
module rpa_line_addr (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic raster,
  input wire logic [rpa_pkg::DATA_W-1:0] base,
  input wire logic [rpa_pkg::DATA_W-1:0] stride,
  input wire logic [rpa_pkg::LINE_W-1:0] line,
  output logic addr_valid,
  output logic [rpa_pkg::DATA_W-1:0] addr
);
  logic valid_ff, nxt_valid;
  logic [rpa_pkg::DATA_W-1:0] addr_ff, nxt_addr;
  logic [rpa_pkg::PROD_W-1:0] prod;

  always_comb begin
    // Stride and result are byte counts; wrap at 32 bits like the bus
    prod = stride * line; // RULE2
    nxt_valid = req_valid;
    nxt_addr = addr_ff;
    if (req_valid) begin
      if (raster) begin
        nxt_addr = base + prod[rpa_pkg::DATA_W-1:0]; // RULE1
      end else begin
        nxt_addr = base; // RULE3
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= 1'b0;
      addr_ff <= rpa_pkg::RST_BASE;
    end else begin
      valid_ff <= nxt_valid;
      addr_ff <= nxt_addr;
    end
  end

  assign addr_valid = valid_ff;
  assign addr = addr_ff;
endmodule

// File: hw/rpa_top.sv
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Functional notes
// RULE1: raster line address is base plus stride times line
// RULE2: stride and addresses count bytes
// RULE3: sub-picture mode ignores stride entirely
// RULE4: tile width accepts only 16..256 pixel codes
// RULE5: software sets tile width equal to processing unit
// RULE6: software keeps chroma base addresses even
// RULE7: software keeps chroma strides even
// RULE8: bases and strides are 32-bit, reset zero, per plane
// RULE9: reserved tile bits read zero, writes ignored
module rpa_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [rpa_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rpa_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [rpa_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rpa_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rpa_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_req_valid,
  input wire logic [1:0] line_req_plane,
  input wire logic [rpa_pkg::LINE_W-1:0] line_req_index,
  output logic line_addr_valid,
  output logic [rpa_pkg::DATA_W-1:0] line_addr,
  output logic raster_mode,
  output logic [rpa_pkg::TILE_W-1:0] luma_bottom_result_tile_width,
  output logic [rpa_pkg::TILE_W-1:0] chroma_top_result_tile_width,
  output logic [rpa_pkg::TILE_W-1:0] chroma_bottom_result_tile_width
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic aw_got_ff, nxt_aw_got;
  logic [rpa_pkg::ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
  logic w_got_ff, nxt_w_got;
  logic [rpa_pkg::DATA_W-1:0] w_data_ff, nxt_w_data;
  logic [rpa_pkg::STRB_W-1:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [rpa_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic raster_ff, nxt_raster;
  logic [rpa_pkg::NPLANE-1:0] refused_ff, nxt_refused;
  logic [rpa_pkg::DATA_W-1:0] last_addr_ff, nxt_last_addr;

  logic wr_fire;
  logic rd_fire;
  rpa_pkg::rpa_slot_t wslot;
  rpa_pkg::rpa_slot_t rslot;
  logic [rpa_pkg::DATA_W-1:0] rd_value;
  logic rd_hit;
  logic [rpa_pkg::DATA_W-1:0] ctrl_merged;
  logic [rpa_pkg::DATA_W-1:0] stat_clear;

  logic [rpa_pkg::DATA_W-1:0] base_v [rpa_pkg::NPLANE];
  logic [rpa_pkg::DATA_W-1:0] stride_v [rpa_pkg::NPLANE];
  logic [rpa_pkg::TILE_W-1:0] tile_v [rpa_pkg::NPLANE];
  logic [rpa_pkg::NPLANE-1:0] refused_set;

  logic sel_valid;
  logic [rpa_pkg::DATA_W-1:0] sel_base;
  logic [rpa_pkg::DATA_W-1:0] sel_stride;
  logic calc_valid;
  logic [rpa_pkg::DATA_W-1:0] calc_addr;

  rpa_plane_if pif [rpa_pkg::NPLANE] ();

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are parked separately so either may come first
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wslot = rpa_pkg::slot_decode(aw_addr_ff);

  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_got = w_got_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_got = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_got = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      if (wslot.kind == rpa_pkg::KIND_NONE) begin
        nxt_bresp = rpa_pkg::RESP_SLVERR;
      end else begin
        nxt_bresp = rpa_pkg::RESP_OKAY;
      end
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_got_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= rpa_pkg::RESP_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      aw_addr_ff <= nxt_aw_addr;
      w_got_ff <= nxt_w_got;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ----------------------------------------------------------------
  // Per-plane register sets
  // ----------------------------------------------------------------
  for (genvar g = 0; g < rpa_pkg::NPLANE; g++) begin : g_plane
    assign pif[g].wr_base = wr_fire && (wslot.kind == rpa_pkg::KIND_BASE) &&
      (wslot.plane == rpa_pkg::rpa_plane_t'(g));
    assign pif[g].wr_stride = wr_fire && (wslot.kind == rpa_pkg::KIND_STRIDE) &&
      (wslot.plane == rpa_pkg::rpa_plane_t'(g));
    assign pif[g].wr_tile = wr_fire && (wslot.kind == rpa_pkg::KIND_TILE) &&
      (wslot.plane == rpa_pkg::rpa_plane_t'(g));
    assign pif[g].wdata = w_data_ff;
    assign pif[g].wstrb = w_strb_ff;
    assign base_v[g] = pif[g].base;
    assign stride_v[g] = pif[g].stride;
    assign tile_v[g] = pif[g].tile;
    assign refused_set[g] = pif[g].tile_refused;

    rpa_plane_regs u_regs (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pif(pif[g])
    );
  end

  // ----------------------------------------------------------------
  // Control, status and last address
  // ----------------------------------------------------------------
  assign ctrl_merged = rpa_pkg::merge_bytes(
    {{(rpa_pkg::DATA_W-1){1'b0}}, raster_ff}, w_data_ff, w_strb_ff);
  assign stat_clear = rpa_pkg::merge_bytes('0, w_data_ff, w_strb_ff);

  always_comb begin
    nxt_raster = raster_ff;
    nxt_refused = refused_ff;
    nxt_last_addr = last_addr_ff;
    if (wr_fire && (wslot.kind == rpa_pkg::KIND_CTRL)) begin
      nxt_raster = ctrl_merged[rpa_pkg::CTRL_RASTER_BIT];
    end
    if (wr_fire && (wslot.kind == rpa_pkg::KIND_STATUS)) begin
      nxt_refused = refused_ff &
        ~stat_clear[rpa_pkg::STAT_REFUSED_LSB +: rpa_pkg::NPLANE];
    end
    // A refusal landing with its own clear still shows
    nxt_refused = nxt_refused | refused_set; // RULE4
    if (calc_valid) begin
      nxt_last_addr = calc_addr;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      raster_ff <= rpa_pkg::RST_RASTER;
      refused_ff <= '0;
      last_addr_ff <= rpa_pkg::RST_BASE;
    end else begin
      raster_ff <= nxt_raster;
      refused_ff <= nxt_refused;
      last_addr_ff <= nxt_last_addr;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rslot = rpa_pkg::slot_decode(s_axi_araddr);

  always_comb begin
    rd_value = '0;
    rd_hit = 1'b1;
    case (rslot.kind)
      rpa_pkg::KIND_BASE: begin
        if (rslot.plane != rpa_pkg::PLANE_NONE) begin
          rd_value = base_v[rslot.plane];
        end
      end
      rpa_pkg::KIND_STRIDE: begin
        if (rslot.plane != rpa_pkg::PLANE_NONE) begin
          rd_value = stride_v[rslot.plane];
        end
      end
      rpa_pkg::KIND_TILE: begin
        // Upper bits stay zero
        if (rslot.plane != rpa_pkg::PLANE_NONE) begin
          rd_value[rpa_pkg::TILE_W-1:0] = tile_v[rslot.plane]; // RULE9
        end
      end
      rpa_pkg::KIND_CTRL: begin
        rd_value[rpa_pkg::CTRL_RASTER_BIT] = raster_ff;
      end
      rpa_pkg::KIND_STATUS: begin
        rd_value[rpa_pkg::STAT_REFUSED_LSB +: rpa_pkg::NPLANE] = refused_ff;
      end
      rpa_pkg::KIND_LAST: begin
        rd_value = last_addr_ff;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (rd_fire) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_value;
      nxt_rresp = rd_hit ? rpa_pkg::RESP_OKAY : rpa_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= rpa_pkg::RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ----------------------------------------------------------------
  // Line address engine port
  // ----------------------------------------------------------------
  // Plane code 3 selects nothing and produces no answer
  always_comb begin
    sel_valid = 1'b0;
    sel_base = rpa_pkg::RST_BASE;
    sel_stride = rpa_pkg::RST_STRIDE;
    if (line_req_plane != rpa_pkg::PLANE_NONE) begin
      sel_valid = line_req_valid;
      sel_base = base_v[line_req_plane]; // RULE1
      sel_stride = stride_v[line_req_plane]; // RULE1
    end
  end

  rpa_line_addr u_line_addr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .req_valid(sel_valid),
    .raster(raster_ff),
    .base(sel_base),
    .stride(sel_stride),
    .line(line_req_index),
    .addr_valid(calc_valid),
    .addr(calc_addr)
  );

  assign line_addr_valid = calc_valid;
  assign line_addr = calc_addr;
  assign raster_mode = raster_ff;
  assign luma_bottom_result_tile_width = tile_v[rpa_pkg::PLANE_LUMA_BTM];
  assign chroma_top_result_tile_width = tile_v[rpa_pkg::PLANE_CHROMA_TOP];
  assign chroma_bottom_result_tile_width = tile_v[rpa_pkg::PLANE_CHROMA_BTM];

endmodule

// File: tb/rpa_top_props.sv
`timescale 1ns/1ps
module rpa_top_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [rpa_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_req_valid,
  input wire logic [1:0] line_req_plane,
  input wire logic line_addr_valid,
  input wire logic [rpa_pkg::DATA_W-1:0] line_addr,
  input wire logic raster_mode,
  input wire logic [rpa_pkg::TILE_W-1:0] luma_bottom_result_tile_width,
  input wire logic [rpa_pkg::TILE_W-1:0] chroma_top_result_tile_width,
  input wire logic [rpa_pkg::TILE_W-1:0] chroma_bottom_result_tile_width
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  function automatic logic legal(input logic [rpa_pkg::TILE_W-1:0] w);
    return $onehot(w[8:4]) && (w[3:0] == 4'h0);
  endfunction

  property p_line_answer;
    line_req_valid && line_req_plane != 2'h3 |=> line_addr_valid;
  endproperty
  a_line_answer: assert property (p_line_answer) else $error("line request unanswered");
  property p_line_quiet;
    !line_req_valid || line_req_plane == 2'h3 |=> !line_addr_valid;
  endproperty
  a_line_quiet: assert property (p_line_quiet) else $error("line answer without request");
  // Base moves only after a write lands
  property p_subpic_const;
    line_req_valid && $past(line_req_valid) && line_req_plane != 2'h3 &&
      line_req_plane == $past(line_req_plane) && !raster_mode && !$past(raster_mode) &&
      !$rose(s_axi_bvalid) |=> line_addr == $past(line_addr);
  endproperty
  a_subpic_const: assert property (p_subpic_const) else $error("stride used in tiles");
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && !s_axi_arready;
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_tile_legal;
    legal(luma_bottom_result_tile_width) && legal(chroma_top_result_tile_width) &&
      legal(chroma_bottom_result_tile_width);
  endproperty
  a_tile_legal: assert property (p_tile_legal) else $error("reserved tile width held");
  property p_tile_by_write;
    $changed({luma_bottom_result_tile_width, chroma_top_result_tile_width,
      chroma_bottom_result_tile_width}) |-> $rose(s_axi_bvalid);
  endproperty
  a_tile_by_write: assert property (p_tile_by_write) else $error("tile width moved");

  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == rpa_pkg::RESP_SLVERR);
  c_raster: cover property (line_addr_valid && raster_mode);
  c_subpic: cover property (line_addr_valid && !raster_mode);
endmodule

bind rpa_top rpa_top_props i_rpa_top_props (.*);

// File: tb/result_picture_address_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module result_picture_address_regs_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic line_req_valid = 1'b0;
  logic [1:0] line_req_plane = 2'h0;
  logic [11:0] line_req_index = 12'h000;
  logic line_addr_valid;
  logic [31:0] line_addr;
  logic raster_mode;
  logic [8:0] luma_bottom_result_tile_width;
  logic [8:0] chroma_top_result_tile_width;
  logic [8:0] chroma_bottom_result_tile_width;
  int err_total = 0;
  int samples_checked = 0;
  localparam logic [1:0] okay = rpa_pkg::RESP_OKAY;
  wire [26:0] tw = {chroma_bottom_result_tile_width, chroma_top_result_tile_width,
    luma_bottom_result_tile_width};
  logic [7:0] ofs [9] = '{rpa_pkg::OFS_LB_BASE, rpa_pkg::OFS_LB_TILE, rpa_pkg::OFS_LB_STRIDE,
    rpa_pkg::OFS_CT_BASE, rpa_pkg::OFS_CT_TILE, rpa_pkg::OFS_CT_STRIDE,
    rpa_pkg::OFS_CB_BASE, rpa_pkg::OFS_CB_TILE, rpa_pkg::OFS_CB_STRIDE};
  logic [8:0] codes [5] = '{rpa_pkg::TILE_16, rpa_pkg::TILE_32, rpa_pkg::TILE_64,
    rpa_pkg::TILE_128, rpa_pkg::TILE_256};

  rpa_top i_rpa_top (.*);

  initial forever #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Bus and line-port tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    int n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    `CHK({s_axi_bvalid, s_axi_bresp}, {1'b1, er})
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    `CHK({s_axi_rvalid, s_axi_rresp}, {1'b1, er})
  endtask

  // Two back-to-back requests on one plane
  task automatic ln2(input logic [1:0] p, input logic [11:0] i0, input logic [11:0] i1,
    input logic ev, input logic [31:0] e0, input logic [31:0] e1);
    @(posedge clk_sys);
    line_req_valid <= 1'b1;
    line_req_plane <= p;
    line_req_index <= i0;
    @(posedge clk_sys);
    line_req_index <= i1;
    #1;
    `CHK(line_addr_valid, ev)
    if (ev) `CHK(line_addr, e0)
    @(posedge clk_sys);
    line_req_valid <= 1'b0;
    #1;
    `CHK(line_addr_valid, ev)
    if (ev) `CHK(line_addr, e1)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    for (int k = 0; k < 9; k++) begin
      rd(ofs[k], d, okay);
      `CHK(d, (k % 3 == 1) ? 32'h0000_0010 : 32'h0000_0000)
    end
    rd(rpa_pkg::OFS_CTRL, d, okay);
    `CHK(d, 32'h0000_0001)
    `CHK(raster_mode, 1'b1)
  endtask

  task automatic t_rw();
    logic [31:0] d;
    for (int k = 0; k < 9; k++) begin
      if (k % 3 != 1) wr(ofs[k], 32'hF00D_0002 + 32'(k) * 32'h0101_0100, 4'hF, okay);
    end
    for (int k = 0; k < 9; k++) begin
      rd(ofs[k], d, okay);
      if (k % 3 != 1) `CHK(d, 32'hF00D_0002 + 32'(k) * 32'h0101_0100)
    end
    wr(rpa_pkg::OFS_LB_BASE, 32'h1122_3344, 4'hF, okay);
    wr(rpa_pkg::OFS_LB_BASE, 32'hA5A5_A5A5, 4'h2, okay);
    rd(rpa_pkg::OFS_LB_BASE, d, okay);
    `CHK(d, 32'h1122_A544)
  endtask

  task automatic t_tile();
    logic [31:0] d;
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 5; c++) begin
        wr(ofs[p * 3 + 1], {23'h0, codes[c]}, 4'hF, okay);
        rd(ofs[p * 3 + 1], d, okay);
        `CHK(d, {23'h0, codes[c]})
        `CHK(tw[p * 9 +: 9], codes[c])
      end
      wr(ofs[p * 3 + 1], 32'h0000_0011, 4'hF, okay);
      rd(ofs[p * 3 + 1], d, okay);
      `CHK(d, 32'h0000_0100)
      rd(rpa_pkg::OFS_STATUS, d, okay);
      `CHK(d[p], 1'b1)
      wr(rpa_pkg::OFS_STATUS, 32'h1 << p, 4'hF, okay);
      rd(rpa_pkg::OFS_STATUS, d, okay);
      `CHK(d[p], 1'b0)
      wr(ofs[p * 3 + 1], 32'hFFFF_FE20, 4'hF, okay);
      rd(ofs[p * 3 + 1], d, okay);
      `CHK(d, 32'h0000_0020)
    end
  endtask

  task automatic t_line();
    logic [31:0] b, s;
    for (int p = 0; p < 3; p++) begin
      b = 32'h8000_0004 + 32'(2 * p);
      s = 32'hFFF0_1232 + 32'(2 * p);
      wr(ofs[p * 3], b, 4'hF, okay);
      wr(ofs[p * 3 + 2], s, 4'hF, okay);
      ln2(2'(p), 12'h000, 12'hFFF, 1'b1, b, b + s * 32'h0000_0FFF);
      ln2(2'(p), 12'h001, 12'h002, 1'b1, b + s, b + s * 32'h0000_0002);
    end
    ln2(2'h3, 12'h005, 12'h006, 1'b0, 32'h0, 32'h0);
    wr(rpa_pkg::OFS_CTRL, 32'h0000_0000, 4'hF, okay);
    `CHK(raster_mode, 1'b0)
    for (int p = 0; p < 3; p++) begin
      b = 32'h8000_0004 + 32'(2 * p);
      ln2(2'(p), 12'h005, 12'hFFF, 1'b1, b, b);
    end
    rd(rpa_pkg::OFS_LAST_ADDR, s, okay);
    `CHK(s, b)
    wr(rpa_pkg::OFS_CTRL, 32'h0000_0001, 4'hF, okay);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    wr(8'h30, 32'h1234_5678, 4'hF, rpa_pkg::RESP_SLVERR);
    rd(8'h30, d, rpa_pkg::RESP_SLVERR);
    `CHK(d, 32'h0000_0000)
  endtask

  task automatic summarize();
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_rw();
    t_tile();
    t_line();
    t_unmapped();
    summarize();
  end

  // Run takes near 3.5 us
  initial begin
    #200us;
    err_total++;
    summarize();
  end
endmodule
